// ==== verilog/shg_top.sv ====
`default_nettype none
module shg_top
  import shg_pkg::*;
#(
  parameter int DW = SHG_DATA_BITS
) (
  input  wire logic          MCLK,
  input  wire logic          RESETN,
  input  wire logic          LINK_EN,
  input  wire logic          SYSREF_SYNC,
  input  wire logic [1:0]    HEADER_STREAM_FORMAT_SELECT,
  input  wire logic [7:0]    EMB_LENGTH,
  input  wire logic          BLK_VALID,
  input  wire logic [DW-1:0] BLK_DATA,
  output logic               OUT_VALID,
  output logic [65:0]        OUT_BLOCK,
  output logic               MB_START,
  output logic               FORMAT_ERROR
);
  logic [4:0]        blk_idx;
  logic [7:0]        mb_idx;
  logic              first_mb;
  logic [31:0]       stream_word;
  logic [31:0]       next_stream;
  logic [SHG_CRC_W-1:0] crc_state;
  logic [SHG_FEC_W-1:0] fec_state;
  logic [SHG_CRC_W-1:0] crc_hold;
  logic [SHG_FEC_W-1:0] fec_hold;
  logic [SHG_CRC_W-1:0] next_crc_final;
  logic [SHG_FEC_W-1:0] next_fec_final;
  logic [25:0]          crc_full;
  logic              fmt_fec;
  logic              fmt_ok;
  logic              mb_first_blk;
  logic              mb_last_blk;
  logic              emb_last;
  logic [7:0]        e_len;
  logic              stream_bit;

  assign fmt_fec      = (HEADER_STREAM_FORMAT_SELECT == SHG_FMT_FEC);
  assign fmt_ok       = fmt_fec || (HEADER_STREAM_FORMAT_SELECT == SHG_FMT_CRC12);
  assign mb_first_blk = (blk_idx == 5'h00);
  assign mb_last_blk  = (blk_idx == 5'h1F);
  assign e_len        = (EMB_LENGTH == 8'h00) ? SHG_E_DEFAULT : EMB_LENGTH;
  assign emb_last     = (mb_idx == e_len - 8'h01);

  // Builds the multiblock stream word from the held parity of the prior multiblock.
  function automatic logic [31:0] build_stream(input logic fec, input logic [11:0] crc,
                                               input logic [25:0] par, input logic last);
    logic [31:0] s;
    s = '0;
    if (fec) begin
      for (int i = 0; i <= 21; i++) begin
        s[i] = par[25-i];
      end
      s[23] = par[3];
      s[24] = par[2];
      s[25] = par[1];
      s[26] = par[0];
    end else begin
      for (int g = 0; g < 4; g++) begin
        for (int k = 0; k < 3; k++) begin
          s[4*g+k] = crc[11-3*g-k];
        end
      end
      s = s | SHG_CRC_ONES;
    end
    s[SHG_EMB_BIT] = last;
    s[31:SHG_PILOT_LSB] = SHG_PILOT;
    return s;
  endfunction

  always_comb begin
    next_stream = build_stream(fmt_fec, crc_hold, fec_hold, emb_last);
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN || !LINK_EN || SYSREF_SYNC) begin
      blk_idx <= '0;
      mb_idx  <= '0;
    end else if (BLK_VALID) begin
      blk_idx <= blk_idx + 5'h01;
      if (mb_last_blk) begin
        mb_idx <= emb_last ? 8'h00 : mb_idx + 8'h01;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN || !LINK_EN) begin
      first_mb <= 1'b1;
      crc_hold <= '0;
      fec_hold <= '0;
    end else if (BLK_VALID && mb_last_blk) begin
      first_mb <= 1'b0;
      crc_hold <= next_crc_final;
      fec_hold <= next_fec_final;
    end
  end

  // Final parity includes the last block, taken combinationally from the last step.
  function automatic logic [25:0] lfsr_step(input logic [25:0] s, input logic [DW-1:0] d,
                                            input int w, input logic [25:0] poly);
    logic [25:0] r;
    logic        fb;
    r = s;
    for (int i = DW - 1; i >= 0; i--) begin
      fb = r[w-1] ^ d[i];
      r  = (r << 1) ^ (fb ? poly : 26'h0);
      if (w < 26) begin
        r = r & ((26'h1 << w) - 26'h1);
      end
    end
    return r;
  endfunction

  always_comb begin
    crc_full       = lfsr_step({14'h0, crc_state}, BLK_DATA, SHG_CRC_W, {14'h0, SHG_CRC_POLY});
    next_crc_final = crc_full[SHG_CRC_W-1:0];
    next_fec_final = lfsr_step(fec_state, BLK_DATA, SHG_FEC_W, SHG_FEC_POLY);
  end

  shg_parity_lfsr #(
    .W    (SHG_CRC_W),
    .POLY ({14'h0, SHG_CRC_POLY}),
    .DW   (DW)
  ) u_crc (
    .clk   (MCLK),
    .rst_n (RESETN),
    .start (mb_first_blk),
    .en    (BLK_VALID),
    .data  (BLK_DATA),
    .state (crc_state)
  );

  shg_parity_lfsr #(
    .W    (SHG_FEC_W),
    .POLY (SHG_FEC_POLY),
    .DW   (DW)
  ) u_fec (
    .clk   (MCLK),
    .rst_n (RESETN),
    .start (mb_first_blk),
    .en    (BLK_VALID),
    .data  (BLK_DATA),
    .state (fec_state)
  );

  // The stream word is latched at the first block so it stays fixed for 32 blocks.
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      stream_word <= '0;
    end else if (BLK_VALID && mb_first_blk) begin
      stream_word <= next_stream;
    end
  end

  always_comb begin
    stream_bit = mb_first_blk ? next_stream[0] : stream_word[blk_idx];
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      OUT_VALID    <= 1'b0;
      OUT_BLOCK    <= '0;
      MB_START     <= 1'b0;
      FORMAT_ERROR <= 1'b0;
    end else begin
      OUT_VALID    <= BLK_VALID && LINK_EN;
      MB_START     <= BLK_VALID && LINK_EN && mb_first_blk;
      FORMAT_ERROR <= !fmt_ok;
      if (BLK_VALID) begin
        // Header in the top two bits = stream bit at position blk_idx (01 for one, 10 for zero), BLK_DATA follows.
        OUT_BLOCK <= {(stream_bit ? SHG_HDR_ONE : SHG_HDR_ZERO), BLK_DATA};
      end
    end
  end

  a_header_complement: assert property (@(posedge MCLK) disable iff (!RESETN)
    OUT_VALID |-> (OUT_BLOCK[65] != OUT_BLOCK[64]))
    else $error("sync header bits not complementary");

  a_pilot_tail: assert property (@(posedge MCLK) disable iff (!RESETN)
    (BLK_VALID && LINK_EN && blk_idx >= 5'h1B) |=>
      (OUT_BLOCK[65:64] == (($past(blk_idx) == 5'h1F) ? 2'h1 : 2'h2)))
    else $error("pilot pattern wrong");

  a_block_follow: assert property (@(posedge MCLK) disable iff (!RESETN)
    (BLK_VALID && LINK_EN) |=> (OUT_VALID && OUT_BLOCK[63:0] == $past(BLK_DATA)))
    else $error("data block not passed after header");

  a_emb_flag: assert property (@(posedge MCLK) disable iff (!RESETN)
    (BLK_VALID && mb_first_blk) |=> (stream_word[SHG_EMB_BIT] == $past(emb_last)))
    else $error("extended multiblock flag wrong");

  a_crc_ones: assert property (@(posedge MCLK) disable iff (!RESETN)
    (BLK_VALID && mb_first_blk && !fmt_fec) |=> ((stream_word & SHG_CRC_ONES) == SHG_CRC_ONES))
    else $error("fixed ones missing");

  a_cmd_zero: assert property (@(posedge MCLK) disable iff (!RESETN)
    (BLK_VALID && mb_first_blk && !fmt_fec) |=> (stream_word[18:16] == 3'h0 && !stream_word[20] && stream_word[26:24] == 3'h0))
    else $error("command bits not zero");

  a_crc_carry: assert property (@(posedge MCLK) disable iff (!RESETN || !LINK_EN)
    (BLK_VALID && mb_last_blk) |=> (crc_hold == $past(next_crc_final)))
    else $error("crc not carried to next multiblock");

  a_zero_first: assert property (@(posedge MCLK) disable iff (!RESETN)
    (first_mb && LINK_EN) |-> (crc_hold == '0 && fec_hold == '0))
    else $error("first multiblock parity not zero");

  a_fec_map: assert property (@(posedge MCLK) disable iff (!RESETN)
    (BLK_VALID && mb_first_blk && fmt_fec) |=> (stream_word[0] == $past(fec_hold[25]) && stream_word[23] == $past(fec_hold[3])))
    else $error("fec mapping wrong");

  c_mb_start:  cover property (@(posedge MCLK) MB_START);
  c_fec_mode:  cover property (@(posedge MCLK) fmt_fec && BLK_VALID && mb_last_blk);
  c_emb_end:   cover property (@(posedge MCLK) BLK_VALID && mb_last_blk && emb_last && !first_mb);
  c_crc_mode:  cover property (@(posedge MCLK) !fmt_fec && BLK_VALID && mb_last_blk && !first_mb);
  c_realign:   cover property (@(posedge MCLK) SYSREF_SYNC && LINK_EN && blk_idx != 5'h00);
endmodule
`default_nettype wire

// ==== verilog/shg_pkg.sv ====
`default_nettype none
package shg_pkg;
  localparam int                SHG_BLOCKS_PER_MB = 32;
  localparam int                SHG_DATA_BITS     = 64;
  localparam int                SHG_MB_BITS       = 2048;
  localparam int                SHG_CRC_W         = 12;
  localparam int                SHG_FEC_W         = 26;
  localparam logic [11:0]       SHG_CRC_POLY      = 12'h987;
  localparam logic [25:0]       SHG_FEC_POLY      = 26'h0220211;
  localparam logic [1:0]        SHG_FMT_CRC12     = 2'h0;
  localparam logic [1:0]        SHG_FMT_FEC       = 2'h2;
  localparam logic [1:0]        SHG_HDR_ONE       = 2'h1;
  localparam logic [1:0]        SHG_HDR_ZERO      = 2'h2;
  localparam int                SHG_EMB_BIT       = 22;
  localparam logic [4:0]        SHG_PILOT         = 5'h10;
  localparam int                SHG_PILOT_LSB     = 27;
  localparam logic [7:0]        SHG_E_DEFAULT     = 8'h01;
  localparam logic [31:0]       SHG_CRC_ONES      = 32'h00A88888;
endpackage
`default_nettype wire

// ==== verilog/shg_parity_lfsr.sv ====
`default_nettype none
module shg_parity_lfsr
  import shg_pkg::*;
#(
  parameter int          W    = 12,
  parameter logic [25:0] POLY = 26'h0000987,
  parameter int          DW   = 64
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          start,
  input  wire logic          en,
  input  wire logic [DW-1:0] data,
  output logic      [W-1:0]  state
);
  // Serial division, MSB of data (transmission-first bit) first.
  function automatic logic [W-1:0] step(input logic [W-1:0] s, input logic [DW-1:0] d);
    logic [W-1:0] r;
    logic         fb;
    r = s;
    for (int i = DW - 1; i >= 0; i--) begin
      fb = r[W-1] ^ d[i];
      r  = {r[W-2:0], 1'b0} ^ (fb ? POLY[W-1:0] : '0);
    end
    return r;
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= '0;
    end else if (en) begin
      state <= step(start ? '0 : state, data);
    end
  end
endmodule
`default_nettype wire

// ==== tb/shg_rx_model.sv ====
`default_nettype none
module shg_rx_model
  import shg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        link_en,
  input  wire logic        vld,
  input  wire logic        mb_start,
  input  wire logic [65:0] blk,
  output logic             word_done,
  output logic [31:0]      word,
  output logic [11:0]      crc_prev,
  output logic [25:0]      fec_prev,
  output logic [7:0]       hdr_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]  idx;
  logic [4:0]  k;
  logic [31:0] acc;
  logic [25:0] crc;
  logic [25:0] fec;
  logic [25:0] crc_done;
  logic [25:0] fec_done;
  logic [25:0] crc_nx;
  logic [25:0] fec_nx;
  // Serial divider that takes the first bit on the wire first.
  function automatic logic [25:0] step(input logic [25:0] s, input logic [63:0] d, input int w,
                                       input logic [25:0] p);
    logic fb;
    for (int i = 63; i >= 0; i--) begin
      fb = d[i] ^ s[w-1];
      s = ((s << 1) ^ (fb ? p : 26'h0)) & ((26'h1 << w) - 26'h1);
    end
    return s;
  endfunction
  assign k = mb_start ? 5'h0 : idx;
  assign crc_nx = step(mb_start ? 26'h0 : crc, blk[63:0], 12, 26'h0000987);
  assign fec_nx = step(mb_start ? 26'h0 : fec, blk[63:0], 26, 26'h0220211);
  always_ff @(posedge clk) begin
    word_done <= 1'b0;
    if (!rst_n || !link_en) begin
      idx <= 5'h0;
      crc <= 26'h0;
      fec <= 26'h0;
      crc_done <= 26'h0;
      fec_done <= 26'h0;
      hdr_err <= 8'h0;
    end else if (vld) begin
      if (blk[65] == blk[64]) hdr_err <= hdr_err + 8'h1;
      acc[k] <= blk[65:64] == 2'h1;
      idx <= k + 5'h1;
      crc <= crc_nx;
      fec <= fec_nx;
      if (k == 5'h1F) begin
        word_done <= 1'b1;
        word <= {blk[65:64] == 2'h1, acc[30:0]};
        crc_prev <= crc_done[11:0];
        fec_prev <= fec_done;
        crc_done <= crc_nx;
        fec_done <= fec_nx;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/shg_top_tb.sv ====
`default_nettype none
module shg_top_tb
  import shg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        link_en = 1'b0;
  logic [1:0]  fmt = 2'h0;
  logic [7:0]  emb = 8'h1;
  logic        blk_valid = 1'b0;
  logic        sysref = 1'b0;
  logic [63:0] blk_data = 64'h0;
  logic        out_valid, mb_start, format_error, word_done;
  logic [65:0] out_block;
  logic [31:0] word;
  logic [11:0] crc_prev;
  logic [25:0] fec_prev;
  logic [7:0]  hdr_err;
  int          n_mismatch = 0, checks = 0, cycles = 0, mbn = 0;
  always #25 mclk = ~mclk;
  shg_top dut (.MCLK(mclk), .RESETN(resetn), .LINK_EN(link_en), .SYSREF_SYNC(sysref),
    .HEADER_STREAM_FORMAT_SELECT(fmt), .EMB_LENGTH(emb), .BLK_VALID(blk_valid), .BLK_DATA(blk_data),
    .OUT_VALID(out_valid), .OUT_BLOCK(out_block), .MB_START(mb_start), .FORMAT_ERROR(format_error));
  shg_rx_model rx (.clk(mclk), .rst_n(resetn), .link_en(link_en), .vld(out_valid), .mb_start(mb_start),
    .blk(out_block), .word_done(word_done), .word(word), .crc_prev(crc_prev), .fec_prev(fec_prev),
    .hdr_err(hdr_err));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [63:0] dat(input int j);
    return {32'(j) * 32'h9E3779B1, 32'(j) ^ 32'hA5A5F00F};
  endfunction
  function automatic logic [31:0] exp_word(input logic fec, input logic [25:0] p, input logic last);
    logic [31:0] w;
    w = fec ? 32'h0 : 32'h00A88888;
    for (int i = 0; i < 22; i++) begin
      if (fec) w[i] = p[25-i];
      else if (i < 12) w[i+i/3] = p[11-i];
    end
    if (fec) w[26:23] = {p[0], p[1], p[2], p[3]};
    w[22] = last;
    w[31:27] = 5'h10;
    return w;
  endfunction
  // Link enable is dropped so every scenario starts from multiblock zero with cleared parity.
  task automatic restart(input logic [1:0] f, input logic [7:0] e);
    @(posedge mclk);
    link_en <= 1'b0;
    fmt <= f;
    emb <= e;
    repeat (2) @(posedge mclk);
    link_en <= 1'b1;
    mbn = 0;
  endtask
  task automatic run(input int n, input logic fec, input int e);
    for (int i = 0; i < n * 32 + 2; i++) begin
      @(posedge mclk);
      blk_valid <= i < n * 32;
      blk_data <= dat(i);
      #1;
      if (i >= 1 && i <= n * 32) begin
        check(out_valid, 64'h1);
        check(mb_start, 64'((i - 1) % 32 == 0));
        check(out_block[63:0], dat(i - 1));
      end
      if (word_done === 1'b1) begin
        check(word, exp_word(fec, fec ? fec_prev : {14'h0, crc_prev}, mbn % e == e - 1));
        check(hdr_err, 64'h0);
        mbn++;
      end
    end
  endtask
  // A partial multiblock is cut by a realignment pulse; the next block must open a new multiblock.
  task automatic t_sysref();
    restart(2'h0, 8'h1);
    repeat (5) begin
      @(posedge mclk);
      blk_valid <= 1'b1;
      blk_data <= 64'h0123456789ABCDEF;
    end
    @(posedge mclk);
    blk_valid <= 1'b0;
    sysref <= 1'b1;
    @(posedge mclk);
    sysref <= 1'b0;
    run(2, 1'b0, 1);
    check(mbn, 64'h2);
    $display("realign test done");
  endtask
  task automatic t_crc();
    restart(2'h0, 8'h2);
    run(3, 1'b0, 2);
    check(format_error, 64'h0);
    $display("crc test done");
  endtask
  task automatic t_fec();
    restart(2'h2, 8'h3);
    run(4, 1'b1, 3);
    check(format_error, 64'h0);
    $display("fec test done");
  endtask
  task automatic t_bad();
    restart(2'h1, 8'h0);
    run(2, 1'b0, 1);
    check(format_error, 64'h1);
    $display("bad format test done");
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    t_crc();
    t_fec();
    t_bad();
    t_sysref();
    test_done();
  end
endmodule
`default_nettype wire
